// ### dv/imd_bb_source.sv
// Baseband sample source that feeds the datapath on its ready pulses.
`timescale 1ns/1ps
`default_nettype none
module imd_bb_source (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        en,
    input  wire logic [15:0] smp_i,
    input  wire logic [15:0] smp_q,
    input  wire logic        in_ready,
    output logic             in_valid,
    output logic      [15:0] in_i,
    output logic      [15:0] in_q
);
    logic take;

    // Ready is looked at mid-cycle so the edge that takes the pair is known without a race.
    always @(negedge clk) begin
        take <= in_ready;
    end

    // A new pair is launched only after the old one was taken; idle lines show inverted data.
    initial begin
        in_valid = 1'b0;
        in_i     = 16'h0000;
        in_q     = 16'h0000;
        take     = 1'b0;
    end
    always @(posedge clk) begin
        #1;
        if (!en || reset) begin
            in_valid = 1'b0;
            in_i     = ~in_i;
            in_q     = ~in_q;
        end else if (take || !in_valid) begin
            in_valid = 1'b1;
            in_i     = smp_i;
            in_q     = smp_q;
        end
    end
endmodule : imd_bb_source
`default_nettype wire

// ### dv/tb_interpolation_modulation_datapath.sv
// Self-checking bench for the interpolation, modulation and zero-stuffing datapath.
`timescale 1ns/1ps
`default_nettype none
module tb_interpolation_modulation_datapath;
    logic        clk, reset, reg_wr, reg_rd, in_valid, in_ready, en;
    logic [4:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [15:0] in_i, in_q, dac_i, dac_q, smp_i, smp_q;
    logic [15:0] s [16];
    logic [15:0] ia [8];
    logic [15:0] qa [8];
    logic [7:0]  mc [8] = '{8'h00, 8'hC0, 8'h50, 8'hA0, 8'hF0, 8'h10, 8'h20, 8'h30};
    int          mh [8] = '{0, 0, 1, 2, 4, 1, 2, 4};
    logic [7:0]  rc [7] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'h08, 8'h48, 8'hC8};
    int          bad_count, tests_run, n;

    imd_datapath dut (.clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .in_valid(in_valid), .in_i(in_i), .in_q(in_q), .in_ready(in_ready),
        .dac_i(dac_i), .dac_q(dac_q));
    imd_bb_source src (.clk(clk), .reset(reset), .en(en), .smp_i(smp_i), .smp_q(smp_q),
        .in_ready(in_ready), .in_valid(in_valid), .in_i(in_i), .in_q(in_q));

    // Free-running 50 MHz clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Compares one value and counts the outcome.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    // One register write, strobe held across exactly one taking edge.
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(posedge clk) #1;
        reg_wr    = 1'b0;
    endtask : wr

    // One register read; the registered answer is there after the taking edge.
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        @(posedge clk) #1;
        reg_rd   = 1'b1;
        reg_addr = a;
        @(posedge clk) #1;
        reg_rd   = 1'b0;
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd

    function automatic int per(input logic [7:0] c);
        return (1 << c[7:6]) * (c[3] ? 2 : 1);
    endfunction : per

    // Settles a constant input in one mode, then checks carrier symmetry and peak level.
    task automatic mod_chk(input logic [7:0] c, input int half, input logic [15:0] x);
        logic [15:0] mx;
        smp_i = x;
        smp_q = x;
        wr(5'h01, c);
        repeat (300) @(negedge clk);
        n  = 0;
        while (in_ready !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 20) begin
                chk(16'h0000, 16'h0001);
                finish_test();
            end
        end
        mx = 16'h0000;
        for (int k = 0; k < 16; k++) begin
            @(negedge clk);
            s[k] = dac_i ^ 16'h8000;
            if (!s[k][15] && s[k] > mx) mx = s[k];
        end
        for (int k = 0; k < 16 - half; k++) begin
            chk(half == 0 ? s[k] : s[k] + s[k + half], half == 0 ? x : 16'h0000);
        end
        chk(mx, x);
    endtask : mod_chk

    // Main sequence: reset, registers, rates, modulation, stuffing, complex mix.
    initial begin
        reset     = 1'b1;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 5'h00;
        reg_wdata = 8'h00;
        en        = 1'b0;
        smp_i     = 16'h0000;
        smp_q     = 16'h0000;
        bad_count = 0;
        tests_run = 0;
        void'($urandom(32'haad0));
        repeat (5) @(posedge clk);
        #1 reset = 1'b0;
        en = 1'b1;
        rd(5'h01, 8'h00);
        wr(5'h01, 8'hC1);
        rd(5'h01, 8'hC1);
        wr(5'h03, 8'h55);
        rd(5'h01, 8'hC1);
        rd(5'h02, 8'h00);
        foreach (rc[j]) begin
            wr(5'h01, rc[j]);
            n = 0;
            repeat (32) begin
                @(negedge clk);
                n += (in_ready === 1'b1);
            end
            chk(16'(n), 16'(32 / per(rc[j])));
        end
        foreach (mc[j]) begin
            mod_chk(mc[j], mh[j], j == 5 ? 16'h7FFF : 16'($urandom_range(16000, 1)));
        end
        wr(5'h01, 8'h18);
        repeat (20) @(negedge clk);
        for (int k = 0; k < 16; k++) begin
            @(negedge clk);
            s[k] = dac_i;
        end
        for (int k = 0; k < 14; k++) begin
            chk({15'd0, s[k] == 16'h8000}, {15'd0, s[k + 1] != 16'h8000});
            if (s[k] !== 16'h8000) chk((s[k] ^ 16'h8000) + (s[k + 2] ^ 16'h8000), 16'h0000);
        end
        smp_i = 16'($urandom_range(12000, 1));
        smp_q = 16'h0000;
        for (int p = 0; p < 2; p++) begin
            wr(5'h01, p == 0 ? 8'h24 : 8'h26);
            repeat (4) @(negedge clk);
            for (int k = 0; k < 8; k++) begin
                @(negedge clk);
                chk({15'd0, dac_i == 16'h8000}, {15'd0, dac_q != 16'h8000});
                if (p == 0) begin
                    ia[k] = dac_i;
                    qa[k] = dac_q;
                end else begin
                    chk(dac_i, ia[k]);
                    chk(dac_q ^ 16'h8000, -(qa[k] ^ 16'h8000));
                end
            end
        end
        finish_test();
    end
endmodule : tb_interpolation_modulation_datapath
`default_nettype wire

// ### hw/imd_datapath.sv
// Dual-channel interpolation, modulation and zero-stuffing datapath in front of the converters.
// Behaviour
// - I and Q each have three half-band stages.
// - Control bits 7:6 select off, 2x, 4x, 8x.
// - Control bits 5:4 select modulation, any interpolation.
// - fDAC/2 carrier is +1, -1 repeating.
// - fDAC/4 carrier is 0, +1, 0, -1.
// - fDAC/8 carrier is the eight-term 0.707 sequence.
// - Filters come before the modulator.
// - Quarter and eighth rate carriers peak at unity; outputs are not scaled.
// - Control bit 3 enables zero stuffing.
// - Stuffing doubles rate, inserts midscale after samples.
// - Stuffing sits after the modulator, before converters.
// - Control bit 2 couples modulators into complex at fDAC/4 and fDAC/8 only.
// - Complex carrier sign is software selectable.
// - Complex products of I, Q go out both channels.
// - Control bit 1 selects exponential sign.
// - Output rate is input rate times interpolation, stuffing.
`timescale 1ns/1ps
`default_nettype none
module imd_datapath import imd_pkg::*; #(
    parameter int W = `IMD_W
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic        in_valid,
    input  wire logic [15:0] in_i,
    input  wire logic [15:0] in_q,
    output logic             in_ready,
    output logic      [15:0] dac_i,
    output logic      [15:0] dac_q
);
    imd_top_t    s;
    imd_top_t    next_s;
    imd_interp_t interp;
    imd_mod_t    mode;
    logic        stuff;
    logic        cplx;
    logic        restart;
    logic        tick;
    logic [2:0]  t;
    logic [3:0]  rate;
    logic [3:0]  last;
    imd_coef_t   car_cos;
    imd_coef_t   car_sin;
    imd_smp_t    chain_i;
    imd_smp_t    chain_q;
    imd_smp_t    mix_i;
    imd_smp_t    mix_q;
    imd_smp_t    stage_out [2][3];

    // Carrier term for a modulation rate at a phase index.
    function automatic imd_coef_t carrier(input imd_mod_t m, input logic [2:0] idx);
        imd_coef_t c;
        c = `IMD_COEF_ONE;
        unique case (m)
            IMD_MOD_OFF:  c = `IMD_COEF_ONE;
            IMD_MOD_DIV2: c = idx[0] ? -`IMD_COEF_ONE : `IMD_COEF_ONE;
            IMD_MOD_DIV4: c = idx[0] ? (idx[1] ? -`IMD_COEF_ONE : `IMD_COEF_ONE) : '0;
            IMD_MOD_DIV8: begin
                unique case (idx)
                    3'd0, 3'd4: c = '0;
                    3'd1, 3'd3: c = `IMD_COEF_R707;
                    3'd2:       c = `IMD_COEF_ONE;
                    3'd5, 3'd7: c = -`IMD_COEF_R707;
                    3'd6:       c = -`IMD_COEF_ONE;
                endcase
            end
        endcase
        return c;
    endfunction : carrier

    // Sum of two Q15 products, rescaled and clipped to the sample range.
    function automatic imd_smp_t mix(input imd_smp_t a, input imd_coef_t ca,
                                     input imd_smp_t b, input imd_coef_t cb);
        logic signed [35:0] p;
        p = 36'(a) * 36'(ca) + 36'(b) * 36'(cb);
        // Round toward zero so a negated carrier gives an exactly negated sample.
        if (p < 36'sd0) begin
            p = p + 36'sd32767;
        end
        p = p >>> `IMD_FRAC_BITS;
        if (p > 36'sd32767) begin
            return 16'sh7FFF;
        end else if (p < -36'sd32768) begin
            return 16'sh8000;
        end
        return p[15:0];
    endfunction : mix

    // Mode decode from the control register.
    always_comb begin
        interp  = imd_interp_t'(s.ctrl[`IMD_INTERP_HI:`IMD_INTERP_LO]);
        mode    = imd_mod_t'(s.ctrl[`IMD_MOD_HI:`IMD_MOD_LO]);
        stuff   = s.ctrl[`IMD_STUFF_BIT];
        cplx    = s.ctrl[`IMD_CPLX_BIT] && (mode == IMD_MOD_DIV4 || mode == IMD_MOD_DIV8);
        restart = reg_wr && reg_addr == `IMD_CTRL_ADDR;
        rate    = 4'd1 << interp;
        last    = stuff ? 4'((rate << 1) - 4'd1) : 4'(rate - 4'd1);
        tick    = !stuff || !s.cnt[0];
        t       = stuff ? s.cnt[3:1] : s.cnt[2:0];
    end

    // One input pair per rate-counter period; held low while software rewrites the mode.
    assign in_ready = tick && t == 3'd0 && !restart;

    // Three cascaded stages per channel, each strobed at its own rate.
    for (genvar c = 0; c < 2; c++) begin : g_chan
        for (genvar st = 0; st < 3; st++) begin : g_stage
            imd_stage_if sif ();
            logic [3:0] in_mask;
            logic [3:0] out_mask;
            assign in_mask  = 4'((rate >> st) - 4'd1);
            assign out_mask = 4'((rate >> (st + 1)) - 4'd1);
            assign sif.in_stb  = st < int'(interp) && tick && !restart &&
                                 ({1'b0, t} & in_mask) == (4'(st % 2) & in_mask);
            assign sif.out_stb = st < int'(interp) && tick && !restart &&
                                 ({1'b0, t} & out_mask) == (4'(st % 2) & out_mask);
            if (st == 0) begin : g_first
                assign sif.in_data = (c == 0) ? s.xi : s.xq;
            end else begin : g_next
                assign sif.in_data = stage_out[c][st-1];
            end
            assign stage_out[c][st] = sif.out_data;
            imd_halfband u_hb (
                .clk   (clk),
                .reset (reset),
                .sif   (sif.stage)
            );
        end
    end

    // Filtered samples feed the modulator, or raw input when interpolation is off.
    always_comb begin
        chain_i = s.xi;
        chain_q = s.xq;
        if (interp != IMD_INTERP_OFF) begin
            chain_i = stage_out[0][int'(interp)-1];
            chain_q = stage_out[1][int'(interp)-1];
        end
    end

    // Real mode scales both paths by one carrier; complex mode rotates I+jQ.
    always_comb begin
        car_cos = carrier(mode, s.ph);
        car_sin = '0;
        if (cplx) begin
            car_cos = carrier(mode, mode == IMD_MOD_DIV8 ? 3'(s.ph + 3'd2) : 3'(s.ph + 3'd1));
            car_sin = s.ctrl[`IMD_NEG_BIT] ? -carrier(mode, s.ph) : carrier(mode, s.ph);
        end
        mix_i = mix(chain_i, car_cos, chain_q, -car_sin);
        mix_q = mix(chain_i, car_sin, chain_q, car_cos);
    end

    // Next-state logic: registers, rate counter, carrier phase, input capture, output.
    always_comb begin
        next_s       = s;
        next_s.rdata = s.rdata;
        if (reg_rd) begin
            next_s.rdata = (reg_addr == `IMD_CTRL_ADDR) ? s.ctrl : 8'h00;
        end
        if (restart) begin
            next_s.ctrl = reg_wdata;
            next_s.cnt  = '0;
            next_s.ph   = '0;
        end else begin
            next_s.cnt = (s.cnt == last) ? 4'd0 : 4'(s.cnt + 4'd1);
            if (tick) begin
                next_s.ph = 3'(s.ph + 3'd1);
            end
        end
        if (in_ready) begin
            next_s.xi = in_valid ? in_i : '0;
            next_s.xq = in_valid ? in_q : '0;
        end
        if (tick) begin
            next_s.dac_i = mix_i ^ `IMD_MIDSCALE;
            next_s.dac_q = mix_q ^ `IMD_MIDSCALE;
        end else begin
            next_s.dac_i = `IMD_MIDSCALE;
            next_s.dac_q = `IMD_MIDSCALE;
        end
    end

    // State register.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s      <= '0;
            s.ctrl <= `IMD_CTRL_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign dac_i     = s.dac_i;
    assign dac_q     = s.dac_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    stuff_midscale_a: assert property (stuff && !tick |=> dac_i == 16'h8000 && dac_q == 16'h8000)
        else $error("stuffed slot not midscale");
    stuff_alternate_a: assert property (stuff && !restart ##1 stuff && !restart |-> tick != $past(tick))
        else $error("stuffing does not alternate");
    rate_eight_a: assert property (in_ready && interp == IMD_INTERP_X8 && !stuff && !reg_wr
        ##1 (!reg_wr)[*8]
        |-> in_ready && !$past(in_ready, 1) && !$past(in_ready, 4) && !$past(in_ready, 7))
        else $error("8x input period wrong");
    bypass_path_a: assert property (in_ready && in_valid && interp == IMD_INTERP_OFF && mode == IMD_MOD_OFF
        && !stuff && !reg_wr ##1 !reg_wr |=> dac_i == ($past(in_i, 2) ^ 16'h8000))
        else $error("bypass sample mismatch");
    phase_step_a: assert property (tick && !restart |=> s.ph == 3'($past(s.ph) + 3'd1))
        else $error("carrier phase did not step");
    phase_reset_a: assert property (restart |=> s.ph == 3'd0 && s.cnt == 4'd0)
        else $error("phase not cleared");
    half_carrier_a: assert property (mode == IMD_MOD_DIV2 && !cplx
        |-> car_cos == (s.ph[0] ? -18'sh0_8000 : 18'sh0_8000))
        else $error("fDAC/2 carrier wrong");
    quarter_carrier_a: assert property (mode == IMD_MOD_DIV4 && !cplx && s.ph[1:0] == 2'd3
        |-> car_cos == -18'sh0_8000)
        else $error("fDAC/4 carrier wrong");
    eighth_carrier_a: assert property (mode == IMD_MOD_DIV8 && !cplx && s.ph == 3'd2
        |-> car_cos == 18'sh0_8000 && carrier(mode, 3'd5) == -18'sh0_5A82)
        else $error("fDAC/8 carrier wrong");
    cplx_quad_a: assert property (cplx && mode == IMD_MOD_DIV4 && s.ph[1:0] == 2'd0
        |-> car_cos == 18'sh0_8000 && car_sin == 18'sh0)
        else $error("complex quadrature wrong");
    cplx_sign_a: assert property (cplx && s.ctrl[1] |-> car_sin == -carrier(mode, s.ph))
        else $error("complex sign wrong");
    reg_read_a: assert property (reg_rd && reg_addr == 5'h01 |=> reg_rdata == $past(s.ctrl))
        else $error("control readback wrong");

    stuff_run_c: cover property (stuff && tick ##1 stuff && !tick);
    cplx_run_c: cover property (cplx && interp == IMD_INTERP_X8 && in_ready);
    eight_x_c: cover property (interp == IMD_INTERP_X8 && mode == IMD_MOD_DIV8 && in_ready && in_valid);
endmodule : imd_datapath
`default_nettype wire

// ### hw/imd_halfband.sv
// One 2x half-band interpolation stage with a four-sample delay line.
`timescale 1ns/1ps
`default_nettype none
module imd_halfband import imd_pkg::*; (
    input wire logic   clk,
    input wire logic   reset,
    imd_stage_if.stage sif
);
    imd_hb_t           s;
    imd_hb_t           next_s;
    logic signed [21:0] acc;

    // Shift on a new input, then emit the center tap or the interpolated midpoint.
    always_comb begin
        next_s = s;
        acc    = '0;
        if (sif.in_stb) begin
            next_s.d0  = sif.in_data;
            next_s.d1  = s.d0;
            next_s.d2  = s.d1;
            next_s.d3  = s.d2;
            next_s.odd = 1'b0;
        end
        // Taps -1, 9, 9, -1 over 16 give unity gain at the midpoint.
        acc = 22'(9 * (22'(next_s.d1) + 22'(next_s.d2))) - 22'(next_s.d0) - 22'(next_s.d3);
        acc = acc >>> 4;
        if (sif.out_stb) begin
            if (!next_s.odd) begin
                next_s.y = next_s.d2;
            end else if (acc > 22'sd32767) begin
                next_s.y = 16'sh7FFF;
            end else if (acc < -22'sd32768) begin
                next_s.y = 16'sh8000;
            end else begin
                next_s.y = acc[15:0];
            end
            next_s.odd = ~next_s.odd;
        end
    end

    // State register.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sif.out_data = s.y;

    // A new input with an output strobe emits the center tap one cycle later.
    hb_center_a: assert property (@(posedge clk) disable iff (reset)
        sif.out_stb && sif.in_stb |=> s.y == $past(s.d1))
        else $error("center tap not emitted");
endmodule : imd_halfband
`default_nettype wire

// ### hw/imd_map.svh
// Register offsets, field positions, reset values and fixed-point constants of the datapath.
`ifndef IMD_MAP_SVH
`define IMD_MAP_SVH

`define IMD_W          16
`define IMD_CTRL_ADDR  5'h01
`define IMD_CTRL_RESET 8'h00
`define IMD_INTERP_HI  7
`define IMD_INTERP_LO  6
`define IMD_MOD_HI     5
`define IMD_MOD_LO     4
`define IMD_STUFF_BIT  3
`define IMD_CPLX_BIT   2
`define IMD_NEG_BIT    1
`define IMD_MIDSCALE   16'h8000
`define IMD_COEF_ONE   18'sh0_8000
`define IMD_COEF_R707  18'sh0_5A82
`define IMD_FRAC_BITS  15

`endif

// ### hw/imd_pkg.sv
// Types shared by the interpolation and modulation datapath.
package imd_pkg;
`include "imd_map.svh"

    typedef enum logic [1:0] {IMD_INTERP_OFF, IMD_INTERP_X2, IMD_INTERP_X4, IMD_INTERP_X8} imd_interp_t;
    typedef enum logic [1:0] {IMD_MOD_OFF, IMD_MOD_DIV2, IMD_MOD_DIV4, IMD_MOD_DIV8} imd_mod_t;

    typedef logic signed [`IMD_W-1:0] imd_smp_t;
    typedef logic signed [17:0]       imd_coef_t;

    // Whole state of the top module.
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [3:0]  cnt;
        logic [2:0]  ph;
        imd_smp_t    xi;
        imd_smp_t    xq;
        logic [15:0] dac_i;
        logic [15:0] dac_q;
        logic [7:0]  rdata;
    } imd_top_t;

    // Whole state of one half-band stage.
    typedef struct packed {
        imd_smp_t d0;
        imd_smp_t d1;
        imd_smp_t d2;
        imd_smp_t d3;
        logic     odd;
        imd_smp_t y;
    } imd_hb_t;
endpackage : imd_pkg

// ### hw/imd_stage_if.sv
// Strobes and samples between the rate controller and one half-band stage.
`timescale 1ns/1ps
`default_nettype none
interface imd_stage_if;
    import imd_pkg::*;
    logic     in_stb;
    logic     out_stb;
    imd_smp_t in_data;
    imd_smp_t out_data;
    modport stage (input in_stb, input out_stb, input in_data, output out_data);
    modport ctrl  (output in_stb, output out_stb, output in_data, input out_data);
endinterface : imd_stage_if
`default_nettype wire
